// *** core/scifc_regs.sv ***
// control, routing and queue configuration register bank
`timescale 1ns/100ps
`default_nettype none
module scifc_regs (
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  input  wire logic                       spiSck,
  input  wire logic                       spiCsN,
  input  wire logic                       spiMosi,
  output var  logic                       spiMiso,
  output var  logic                       spiMisoOe,
  output var  logic [2:0]                 nvmAddr,
  input  wire logic [7:0]                 nvmData,
  output var  logic [63:0]                trimRegs,
  output var  logic                       trimBusy,
  output var  logic                       oneShotStart,
  input  wire logic                       measDone,
  output var  logic [2:0]                 outputRate,
  output var  logic                       lowNoiseMode,
  input  wire logic                       dataReady,
  input  wire logic [7:0]                 fifoLevel,
  input  wire logic                       fifoOverwritten,
  input  wire logic                       pressHighEvt,
  input  wire logic                       pressLowEvt,
  output var  scifc_pkg::scifc_fifo_mode_type fifoMode,
  output var  logic                       haltAtThreshold,
  output var  logic [4:0]                 thresholdLevel,
  input  wire logic                       autoZeroEn,
  input  wire logic                       autoRefEn,
  input  wire logic                       refCapture,
  input  wire logic [15:0]                refValue,
  input  wire logic [23:0]                fifoPressData,
  input  wire logic [15:0]                fifoTempData,
  output var  logic                       fifoPop,
  output var  logic                       eventPinOut,
  output var  logic                       eventPinOe
);
  import scifc_pkg::*;

  // ==========================================================
  // state
  logic [6:0]          addr_ff;
  logic                isRead_ff;
  logic [6:0]          ctrlOne_ff;
  logic                polarity_ff;
  logic                driveType_ff;
  logic                autoInc_ff;
  logic                lowNoise_ff;
  logic [5:0]          route_ff;
  logic [3:0]          fifoCtrl_ff;
  logic [4:0]          thr_ff;
  logic [15:0]         ref_ff;
  logic                swPend_ff;
  logic                oneShot_ff;
  logic                oneShotStart_ff;
  scifc_boot_type      boot_ff;
  logic [2:0]          trimIdx_ff;
  logic                trimBusy_ff;
  logic [7:0]          trimMem [TRIM_WORDS];
  logic                lowNoiseMode_ff;
  scifc_fifo_mode_type fifoMode_ff;
  logic                fifoPop_ff;
  logic                eventPinOut_ff;
  logic                eventPinOe_ff;

  // ==========================================================
  // decode
  scifc_spi_if spiBus ();
  logic [7:0]          wrData;
  logic                wrStrobe;
  logic                wrCtrlOne;
  logic                wrCtrlTwo;
  logic                wrRoute;
  logic                wrFifoCtrl;
  logic                wrThr;
  logic                addrLoad;
  logic                advance;
  logic [6:0]          addrStep;
  logic [6:0]          nxt_addr;
  logic [2:0]          rate;
  logic                oneShotReq;
  logic                nxt_oneShot;
  logic                bootReq;
  scifc_boot_type      nxt_boot;
  logic [2:0]          nxt_trimIdx;
  logic [7:0]          ctrlTwoRd;
  logic [7:0]          rdByte;
  logic                fullFlag;
  logic                thrFlag;
  logic                dataSig;
  logic [1:0]          srcSel;
  logic                srcActive;
  logic                pinLevel;
  logic [1:0]          fMode;
  scifc_fifo_mode_type nxt_fifoMode;

  scifc_spi_slave uSpi (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .sck     (spiSck),
    .csN     (spiCsN),
    .mosi    (spiMosi),
    .miso    (spiMiso),
    .misoOe  (spiMisoOe),
    .bus     (spiBus.slave)
  );

  assign wrData     = spiBus.byteData;
  assign wrStrobe   = spiBus.byteValid & ~spiBus.firstByte & ~isRead_ff;
  assign wrCtrlOne  = wrStrobe & (addr_ff == ADDR_CTRL_ONE);
  assign wrCtrlTwo  = wrStrobe & (addr_ff == ADDR_CTRL_TWO);
  assign wrRoute    = wrStrobe & (addr_ff == ADDR_INT_ROUTE);
  assign wrFifoCtrl = wrStrobe & (addr_ff == ADDR_FIFO_MODE);
  assign wrThr      = wrStrobe & (addr_ff == ADDR_FIFO_THR);
  assign addrLoad   = spiBus.byteValid & spiBus.firstByte;
  assign advance    = wrStrobe | spiBus.txTake;
  assign addrStep   = autoInc_ff ? 7'h01 : 7'h00;
  assign nxt_addr   = addrLoad ? wrData[6:0] : (advance ? addr_ff + addrStep : addr_ff);
  assign spiBus.readMode = isRead_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff   <= 7'h00;
      isRead_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      if (addrLoad) begin
        isRead_ff <= wrData[7];
      end
    end
  end

  // ==========================================================
  // control registers
  assign rate = ctrlOne_ff[CTRL1_RATE_LSB +: 3];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      swPend_ff <= 1'b0;
    end else begin
      swPend_ff <= wrCtrlTwo & wrData[CTRL2_SWRST];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlOne_ff   <= CTRL1_RST;
      polarity_ff  <= 1'b0;
      driveType_ff <= 1'b0;
      autoInc_ff   <= INC_RST;
      lowNoise_ff  <= 1'b0;
    end else if (swPend_ff) begin
      ctrlOne_ff   <= CTRL1_RST;
      polarity_ff  <= 1'b0;
      driveType_ff <= 1'b0;
      autoInc_ff   <= INC_RST;
      lowNoise_ff  <= 1'b0;
    end else begin
      if (wrCtrlOne) begin
        ctrlOne_ff <= wrData[6:0];
      end
      if (wrCtrlTwo) begin
        polarity_ff  <= wrData[CTRL2_POL];
        driveType_ff <= wrData[CTRL2_DRIVE];
        autoInc_ff   <= wrData[CTRL2_INC];
        lowNoise_ff  <= wrData[CTRL2_LOWN];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_ff    <= ROUTE_RST;
      fifoCtrl_ff <= FCTRL_RST;
      thr_ff      <= THR_RST;
    end else if (swPend_ff) begin
      route_ff    <= ROUTE_RST;
      fifoCtrl_ff <= FCTRL_RST;
      thr_ff      <= THR_RST;
    end else begin
      if (wrRoute) begin
        route_ff <= wrData[5:0];
      end
      if (wrFifoCtrl) begin
        fifoCtrl_ff <= wrData[3:0];
      end
      if (wrThr) begin
        thr_ff <= wrData[4:0];
      end
    end
  end

  // ==========================================================
  // reference pressure
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_ff <= REF_RST;
    end else if (swPend_ff) begin
      ref_ff <= REF_RST;
    end else if (refCapture & (autoZeroEn | autoRefEn)) begin
      ref_ff <= refValue;
    end
  end

  // ==========================================================
  // one-shot
  assign oneShotReq  = wrCtrlTwo & wrData[CTRL2_ONESHOT] & (rate == RATE_OFF) & ~oneShot_ff;
  assign nxt_oneShot = oneShotReq | (oneShot_ff & ~measDone & ~swPend_ff);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oneShot_ff      <= 1'b0;
      oneShotStart_ff <= 1'b0;
    end else begin
      oneShot_ff      <= nxt_oneShot;
      oneShotStart_ff <= oneShotReq;
    end
  end

  // ==========================================================
  // trim reload
  assign bootReq = wrCtrlTwo & wrData[CTRL2_BOOT];

  always_comb begin
    nxt_boot    = boot_ff;
    nxt_trimIdx = trimIdx_ff;
    unique case (boot_ff)
      BOOT_IDLE: begin
        if (bootReq) begin
          nxt_boot    = BOOT_COPY;
          nxt_trimIdx = 3'h0;
        end
      end
      BOOT_COPY: begin
        if (trimIdx_ff == TRIM_LAST) begin
          nxt_boot = BOOT_IDLE;
        end else begin
          nxt_trimIdx = trimIdx_ff + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_ff     <= BOOT_COPY;
      trimIdx_ff  <= 3'h0;
      trimBusy_ff <= 1'b1;
    end else begin
      boot_ff     <= nxt_boot;
      trimIdx_ff  <= nxt_trimIdx;
      trimBusy_ff <= (nxt_boot == BOOT_COPY);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (boot_ff == BOOT_COPY) begin
      trimMem[trimIdx_ff] <= nvmData;
    end
  end

  for (genvar gi = 0; gi < TRIM_WORDS; gi++) begin : gTrim
    assign trimRegs[8*gi +: 8] = trimMem[gi];
  end

  // ==========================================================
  // read mux
  assign ctrlTwoRd = {trimBusy_ff, polarity_ff, driveType_ff, autoInc_ff,
                      1'b0, swPend_ff, lowNoise_ff, oneShot_ff};
  assign rdByte =
    (addr_ff == ADDR_CTRL_ONE)      ? {1'b0, ctrlOne_ff} :
    (addr_ff == ADDR_CTRL_TWO)      ? ctrlTwoRd :
    (addr_ff == ADDR_INT_ROUTE)     ? {2'h0, route_ff} :
    (addr_ff == ADDR_FIFO_MODE)     ? {4'h0, fifoCtrl_ff} :
    (addr_ff == ADDR_FIFO_THR)      ? {3'h0, thr_ff} :
    (addr_ff == ADDR_REF_LOW)       ? ref_ff[7:0] :
    (addr_ff == ADDR_REF_HIGH)      ? ref_ff[15:8] :
    (addr_ff == ADDR_FIFO_PRESS_XL) ? fifoPressData[7:0] :
    (addr_ff == ADDR_FIFO_PRESS_L)  ? fifoPressData[15:8] :
    (addr_ff == ADDR_FIFO_PRESS_H)  ? fifoPressData[23:16] :
    (addr_ff == ADDR_FIFO_TEMP_L)   ? fifoTempData[7:0] :
    (addr_ff == ADDR_FIFO_TEMP_H)   ? fifoTempData[15:8] : 8'h00;
  assign spiBus.txByte = rdByte;

  // ==========================================================
  // event pin
  assign fullFlag  = fifoCtrl_ff[FCTRL_HALT] ? (fifoLevel == {3'h0, thr_ff})
                                             : (fifoLevel == FIFO_DEPTH);
  assign thrFlag   = (fifoLevel >= {3'h0, thr_ff});
  assign dataSig   = (route_ff[ROUTE_READY] & dataReady)
                   | (route_ff[ROUTE_THR] & thrFlag)
                   | (route_ff[ROUTE_OVR] & fifoOverwritten)
                   | (route_ff[ROUTE_FULL] & fullFlag);
  assign srcSel    = route_ff[ROUTE_SEL_LSB +: 2];
  assign srcActive = (srcSel == 2'h0) ? dataSig :
                     (srcSel == 2'h1) ? pressHighEvt :
                     (srcSel == 2'h2) ? pressLowEvt : (pressHighEvt | pressLowEvt);
  assign pinLevel  = srcActive ^ polarity_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      eventPinOut_ff <= 1'b0;
      eventPinOe_ff  <= 1'b1;
    end else begin
      eventPinOut_ff <= driveType_ff ? 1'b0 : pinLevel;
      eventPinOe_ff  <= driveType_ff ? ~pinLevel : 1'b1;
    end
  end

  // ==========================================================
  // mode outputs
  assign fMode = fifoCtrl_ff[FCTRL_MODE_LSB +: 2];
  assign nxt_fifoMode =
    (fMode == 2'h0)           ? FM_BYPASS :
    (!fifoCtrl_ff[FCTRL_TRIG]) ? ((fMode == 2'h1) ? FM_FIFO : FM_CONT) :
    (fMode == 2'h1)           ? FM_BYP_TO_FIFO :
    (fMode == 2'h2)           ? FM_BYP_TO_CONT : FM_CONT_TO_FIFO;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fifoMode_ff     <= FM_BYPASS;
      lowNoiseMode_ff <= 1'b0;
      fifoPop_ff      <= 1'b0;
    end else begin
      fifoMode_ff     <= nxt_fifoMode;
      lowNoiseMode_ff <= lowNoise_ff & (rate != RATE_100) & (rate != RATE_200);
      fifoPop_ff      <= spiBus.txTake & (addr_ff == ADDR_FIFO_TEMP_H);
    end
  end

  assign nvmAddr         = trimIdx_ff;
  assign trimBusy        = trimBusy_ff;
  assign oneShotStart    = oneShotStart_ff;
  assign outputRate      = ctrlOne_ff[CTRL1_RATE_LSB +: 3];
  assign lowNoiseMode    = lowNoiseMode_ff;
  assign fifoMode        = fifoMode_ff;
  assign haltAtThreshold = fifoCtrl_ff[FCTRL_HALT];
  assign thresholdLevel  = thr_ff;
  assign fifoPop         = fifoPop_ff;
  assign eventPinOut     = eventPinOut_ff;
  assign eventPinOe      = eventPinOe_ff;
endmodule : scifc_regs
`default_nettype wire

// *** core/scifc_spi_slave.sv ***
// serial slave, clock idles high, sample on rise, shift on fall
`timescale 1ns/100ps
`default_nettype none
module scifc_spi_slave (
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  input  wire logic   sck,
  input  wire logic   csN,
  input  wire logic   mosi,
  output var  logic   miso,
  output var  logic   misoOe,
  scifc_spi_if.slave  bus
);
  logic       sckPrev_ff;
  logic [2:0] bitCnt_ff;
  logic [7:0] rxShift_ff;
  logic [7:0] txShift_ff;
  logic       gotFirst_ff;
  logic       byteValid_ff;
  logic       firstByte_ff;
  logic [7:0] byteData_ff;
  logic       misoOe_ff;
  logic       sckRise;
  logic       sckFall;
  logic       byteDone;
  logic [7:0] rxNext;

  // ==========================================================
  // edge decode
  assign sckRise  = ~csN & sck & ~sckPrev_ff;
  assign sckFall  = ~csN & ~sck & sckPrev_ff;
  assign byteDone = sckRise & (bitCnt_ff == 3'h7);
  assign rxNext   = {rxShift_ff[6:0], mosi};
  assign bus.txTake    = sckFall & (bitCnt_ff == 3'h0) & gotFirst_ff & bus.readMode;
  assign bus.byteValid = byteValid_ff;
  assign bus.firstByte = firstByte_ff;
  assign bus.byteData  = byteData_ff;
  assign miso          = txShift_ff[7];
  assign misoOe        = misoOe_ff;

  // ==========================================================
  // receive side
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_ff   <= 1'b1;
      bitCnt_ff    <= 3'h0;
      rxShift_ff   <= 8'h00;
      gotFirst_ff  <= 1'b0;
      byteValid_ff <= 1'b0;
      firstByte_ff <= 1'b0;
      byteData_ff  <= 8'h00;
    end else begin
      sckPrev_ff   <= sck;
      byteValid_ff <= byteDone;
      if (csN) begin
        bitCnt_ff   <= 3'h0;
        gotFirst_ff <= 1'b0;
      end else if (sckRise) begin
        rxShift_ff <= rxNext;
        bitCnt_ff  <= bitCnt_ff + 3'h1;
      end
      if (byteDone) begin
        byteData_ff  <= rxNext;
        firstByte_ff <= ~gotFirst_ff;
        gotFirst_ff  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // transmit side
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_ff <= 8'h00;
      misoOe_ff  <= 1'b0;
    end else begin
      misoOe_ff <= ~csN & gotFirst_ff & bus.readMode;
      if (bus.txTake) begin
        txShift_ff <= bus.txByte;
      end else if (sckFall) begin
        txShift_ff <= {txShift_ff[6:0], 1'b0};
      end
    end
  end
endmodule : scifc_spi_slave
`default_nettype wire

// *** shared/scifc_pkg.sv ***
// constants and types of the sensor control register bank
`default_nettype none
package scifc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [6:0] ADDR_CTRL_ONE      = 7'h10;
  localparam logic [6:0] ADDR_CTRL_TWO      = 7'h11;
  localparam logic [6:0] ADDR_INT_ROUTE     = 7'h12;
  localparam logic [6:0] ADDR_FIFO_MODE     = 7'h13;
  localparam logic [6:0] ADDR_FIFO_THR      = 7'h14;
  localparam logic [6:0] ADDR_REF_LOW       = 7'h15;
  localparam logic [6:0] ADDR_REF_HIGH      = 7'h16;
  localparam logic [6:0] ADDR_FIFO_PRESS_XL = 7'h78;
  localparam logic [6:0] ADDR_FIFO_PRESS_L  = 7'h79;
  localparam logic [6:0] ADDR_FIFO_PRESS_H  = 7'h7a;
  localparam logic [6:0] ADDR_FIFO_TEMP_L   = 7'h7b;
  localparam logic [6:0] ADDR_FIFO_TEMP_H   = 7'h7c;
  // ==========================================================
  // field positions
  localparam int CTRL1_RATE_LSB = 4;
  localparam int CTRL2_BOOT     = 7;
  localparam int CTRL2_POL      = 6;
  localparam int CTRL2_DRIVE    = 5;
  localparam int CTRL2_INC      = 4;
  localparam int CTRL2_SWRST    = 2;
  localparam int CTRL2_LOWN     = 1;
  localparam int CTRL2_ONESHOT  = 0;
  localparam int ROUTE_FULL     = 5;
  localparam int ROUTE_THR      = 4;
  localparam int ROUTE_OVR      = 3;
  localparam int ROUTE_READY    = 2;
  localparam int ROUTE_SEL_LSB  = 0;
  localparam int FCTRL_HALT     = 3;
  localparam int FCTRL_TRIG     = 2;
  localparam int FCTRL_MODE_LSB = 0;
  // ==========================================================
  // reset values and counts
  localparam logic [6:0]  CTRL1_RST     = 7'h00;
  localparam logic [5:0]  ROUTE_RST     = 6'h00;
  localparam logic [3:0]  FCTRL_RST     = 4'h0;
  localparam logic [4:0]  THR_RST       = 5'h00;
  localparam logic [15:0] REF_RST       = 16'h0000;
  localparam logic        INC_RST       = 1'b1;
  localparam logic [7:0]  FIFO_DEPTH    = 8'h80;
  localparam int          TRIM_WORDS    = 8;
  localparam logic [2:0]  TRIM_LAST     = 3'h7;
  localparam logic [2:0]  RATE_OFF      = 3'h0;
  localparam logic [2:0]  RATE_100      = 3'h6;
  localparam logic [2:0]  RATE_200      = 3'h7;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    FM_BYPASS, FM_FIFO, FM_CONT, FM_BYP_TO_FIFO, FM_BYP_TO_CONT, FM_CONT_TO_FIFO
  } scifc_fifo_mode_type;
  typedef enum logic {BOOT_IDLE, BOOT_COPY} scifc_boot_type;
endpackage : scifc_pkg
`default_nettype wire

// *** shared/scifc_spi_if.sv ***
// byte-level carrier between serial slave and register bank
`timescale 1ns/100ps
`default_nettype none
interface scifc_spi_if;
  logic       byteValid;
  logic       firstByte;
  logic [7:0] byteData;
  logic       txTake;
  logic [7:0] txByte;
  logic       readMode;
  modport slave (output byteValid, firstByte, byteData, txTake, input txByte, readMode);
  modport regs  (input byteValid, firstByte, byteData, txTake, output txByte, readMode);
endinterface : scifc_spi_if
`default_nettype wire

// *** tb/scifc_host_model.sv ***
// serial host model driving the register bank
`timescale 1ns/100ps
`default_nettype none
module scifc_host_model (
  input  wire logic sys_clk,
  output var  logic sck,
  output var  logic csN,
  output var  logic mosi,
  input  wire logic miso
);
  logic [7:0] rxq [5];
  // ==========================================================
  // mode 3 byte transfer, half period of 5 cycles
  initial begin
    sck = 1'b1;
    csN = 1'b1;
    mosi = 1'b1;
  end
  task automatic waitn(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : waitn
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      waitn(5);
      sck = 1'b1;
      rx[i] = miso;
      waitn(5);
    end
  endtask : xfer
  task automatic burst(input logic [7:0] hdr, input logic [7:0] wd, input int n);
    logic [7:0] rx;
    csN = 1'b0;
    waitn(5);
    xfer(hdr, rx);
    for (int k = 0; k < n; k++) xfer(wd, rxq[k]);
    waitn(5);
    csN = 1'b1;
    waitn(10);
  endtask : burst
endmodule : scifc_host_model
`default_nettype wire

// *** tb/scifc_properties.sv ***
// assertion checker bound to the register bank
`timescale 1ns/100ps
`default_nettype none
module scifc_properties
  import scifc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       spiCsN,
  input wire logic       spiMisoOe,
  input wire logic [2:0] nvmAddr,
  input wire logic       trimBusy,
  input wire logic       oneShotStart,
  input wire logic [2:0] outputRate,
  input wire logic       lowNoiseMode,
  input wire logic       fifoPop,
  input wire logic       eventPinOut,
  input wire logic       eventPinOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // properties
  a_shot_lone_pulse: assert property (oneShotStart |=> !oneShotStart [*4])
    else $error("one-shot start is not a lone pulse");
  a_shot_rate_off: assert property (oneShotStart |-> outputRate == RATE_OFF)
    else $error("one-shot start while rate is not off");
  a_lown_forced_off: assert property ((outputRate == RATE_100 || outputRate == RATE_200)
    |=> !lowNoiseMode)
    else $error("low-noise kept at a fast rate");
  a_lown_rise_ok: assert property ($rose(lowNoiseMode) |->
    $past(outputRate) != RATE_100 && $past(outputRate) != RATE_200)
    else $error("low-noise rose at a fast rate");
  a_trim_end_last: assert property ($fell(trimBusy) |-> $past(nvmAddr) == TRIM_LAST)
    else $error("trim copy ended before the last word");
  a_trim_runs_on: assert property (trimBusy && nvmAddr != TRIM_LAST |=> trimBusy)
    else $error("trim copy stopped early");
  a_pin_high_driven: assert property (eventPinOut |-> eventPinOe)
    else $error("event pin high value while not driven");
  a_pop_lone_pulse: assert property (fifoPop |=> !fifoPop)
    else $error("queue pop longer than one cycle");
  a_miso_released: assert property (spiCsN [*3] |-> !spiMisoOe)
    else $error("serial output driven while deselected");
  c_shot: cover property (oneShotStart);
  c_pop: cover property (fifoPop);
  c_boot_end: cover property ($fell(trimBusy));
endmodule : scifc_properties
bind scifc_regs scifc_properties chk_u (.sys_clk, .arst_n, .spiCsN, .spiMisoOe, .nvmAddr,
  .trimBusy, .oneShotStart, .outputRate, .lowNoiseMode, .fifoPop, .eventPinOut, .eventPinOe);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking testbench of the register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import scifc_pkg::*;
  logic                sys_clk, arst_n, measDone, dataReady, fifoOverwritten, pressHighEvt;
  logic                pressLowEvt, autoZeroEn, autoRefEn, refCapture, misoLine, pinLevel;
  logic                spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe, trimBusy, oneShotStart;
  logic                lowNoiseMode, haltAtThreshold, fifoPop, eventPinOut, eventPinOe;
  logic [2:0]          nvmAddr, outputRate;
  logic [4:0]          nvmSeed, thresholdLevel;
  logic [7:0]          fifoLevel, nvmData;
  logic [15:0]         refValue, fifoTempData;
  logic [23:0]         fifoPressData;
  logic [63:0]         trimRegs;
  scifc_fifo_mode_type fifoMode;
  int                  err_total, checked, shotCnt, popCnt;
  assign nvmData = {nvmSeed, nvmAddr};
  assign misoLine = spiMisoOe ? spiMiso : 1'b1;
  assign pinLevel = eventPinOe ? eventPinOut : 1'b1;
  scifc_host_model host_u (.sys_clk(sys_clk), .sck(spiSck), .csN(spiCsN), .mosi(spiMosi),
    .miso(misoLine));
  scifc_regs dut_u (.sys_clk, .arst_n, .spiSck, .spiCsN, .spiMosi, .spiMiso, .spiMisoOe,
    .nvmAddr, .nvmData, .trimRegs, .trimBusy, .measDone, .oneShotStart, .outputRate,
    .lowNoiseMode, .dataReady, .fifoLevel, .fifoOverwritten, .pressHighEvt, .pressLowEvt,
    .fifoMode, .haltAtThreshold, .thresholdLevel, .autoZeroEn, .autoRefEn, .refCapture,
    .refValue, .fifoPressData, .fifoTempData, .fifoPop, .eventPinOut, .eventPinOe);
  // ==========================================================
  // helpers
  always @(posedge sys_clk) begin
    if (oneShotStart === 1'b1) shotCnt++;
    if (fifoPop === 1'b1) popCnt++;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.burst({1'b0, a}, d, 1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input int n);
    host_u.burst({1'b1, a}, 8'h00, n);
  endtask : rd
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic wait_trim(input logic [4:0] seed);
    int k;
    k = 0;
    while (trimBusy !== 1'b0 && k < 200) begin @(negedge sys_clk); k++; end
    if (k == 200) begin err_total++; summarize(); end
    for (int i = 0; i < 8; i++) `CHK("trim", {seed, i[2:0]}, trimRegs[8*i +: 8])
  endtask : wait_trim
  // ==========================================================
  // scenarios
  task automatic t_defaults;
    logic [6:0] ra [6] = '{ADDR_CTRL_TWO, ADDR_INT_ROUTE, ADDR_FIFO_MODE, ADDR_FIFO_THR,
      ADDR_REF_LOW, 7'h20};
    wait_trim(5'h00);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], 1);
      `CHK("default", (i == 0) ? 8'h10 : 8'h00, host_u.rxq[0])
    end
  endtask : t_defaults
  task automatic t_fifo_cfg;
    scifc_fifo_mode_type em [8] = '{FM_BYPASS, FM_FIFO, FM_CONT, FM_CONT, FM_BYPASS,
      FM_BYP_TO_FIFO, FM_BYP_TO_CONT, FM_CONT_TO_FIFO};
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_FIFO_MODE, 8'(i));
      `CHK("mode", em[i % 8], fifoMode)
      `CHK("halt", i[3], haltAtThreshold)
    end
    wr(ADDR_FIFO_THR, 8'hff);
    `CHK("threshold", 5'h1f, thresholdLevel)
  endtask : t_fifo_cfg
  task automatic t_pin;
    logic [23:0] pc [14] = '{24'h040018, 24'h040000, 24'h100a10, 24'h100900, 24'h080014,
      24'h208010, 24'h207f00, 24'h010012, 24'h010001, 24'h020011, 24'h030012,
      24'h030011, 24'h030000, 24'h000008};
    wr(ADDR_FIFO_THR, 8'h0a);
    wr(ADDR_FIFO_MODE, 8'h00);
    for (int i = 0; i < 16; i++) begin
      if (i == 14) wr(ADDR_FIFO_MODE, 8'h08);
      wr(ADDR_INT_ROUTE, (i < 14) ? pc[i][23:16] : 8'h20);
      fifoLevel = (i < 14) ? pc[i][15:8] : 8'(i - 4);
      {dataReady, fifoOverwritten, pressHighEvt, pressLowEvt} = (i < 14) ? pc[i][3:0] : 4'h0;
      repeat (3) @(negedge sys_clk);
      `CHK("pin", (i < 14) ? pc[i][4] : (i == 14), pinLevel)
    end
    fifoLevel = 8'h00;
    wr(ADDR_INT_ROUTE, 8'h04);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL_TWO, {1'b0, i[2], i[1], 5'h10});
      dataReady = i[0];
      repeat (3) @(negedge sys_clk);
      `CHK("level", i[0] ^ i[2], pinLevel)
      `CHK("enable", !i[1] || !(i[0] ^ i[2]), eventPinOe)
    end
    dataReady = 1'b0;
    wr(ADDR_CTRL_TWO, 8'h10);
  endtask : t_pin
  task automatic t_ref;
    logic [17:0] rc [3] = '{{2'b00, 16'h1111}, {2'b01, 16'hb3c5}, {2'b10, 16'h6e27}};
    logic [15:0] expRef;
    expRef = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      {autoZeroEn, autoRefEn} = rc[i][17:16];
      refValue = rc[i][15:0];
      refCapture = 1'b1;
      @(negedge sys_clk);
      refCapture = 1'b0;
      if (rc[i][17:16] != 2'b00) expRef = rc[i][15:0];
      wr(ADDR_REF_LOW, 8'hff);
      rd(ADDR_REF_LOW, 2);
      `CHK("reference", expRef, {host_u.rxq[1], host_u.rxq[0]})
    end
    wr(ADDR_CTRL_TWO, 8'h00);
    rd(ADDR_REF_LOW, 2);
    `CHK("fixed address", 8'h27, host_u.rxq[1])
    wr(ADDR_CTRL_TWO, 8'h10);
  endtask : t_ref
  task automatic t_queue;
    int p0;
    p0 = popCnt;
    rd(ADDR_FIFO_PRESS_XL, 5);
    `CHK("queue", {16'h789a, 24'h123456}, {host_u.rxq[4], host_u.rxq[3], host_u.rxq[2],
      host_u.rxq[1], host_u.rxq[0]})
    `CHK("pops", p0 + 1, popCnt)
    rd(ADDR_FIFO_PRESS_L, 1);
    `CHK("single", 8'h34, host_u.rxq[0])
  endtask : t_queue
  task automatic t_shot_noise;
    logic [7:0] rt [4] = '{8'h00, 8'h60, 8'h70, 8'h50};
    int s0;
    s0 = shotCnt;
    wr(ADDR_CTRL_ONE, 8'h10);
    wr(ADDR_CTRL_TWO, 8'h11);
    `CHK("refused", s0, shotCnt)
    wr(ADDR_CTRL_ONE, 8'h00);
    wr(ADDR_CTRL_TWO, 8'h11);
    rd(ADDR_CTRL_TWO, 1);
    `CHK("busy", 8'h11, host_u.rxq[0])
    `CHK("shots", s0 + 1, shotCnt)
    measDone = 1'b1;
    @(negedge sys_clk);
    measDone = 1'b0;
    rd(ADDR_CTRL_TWO, 1);
    `CHK("cleared", 8'h10, host_u.rxq[0])
    wr(ADDR_CTRL_TWO, 8'h12);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_ONE, rt[i]);
      `CHK("rate", rt[i][6:4], outputRate)
      `CHK("low noise", (i != 1 && i != 2), lowNoiseMode)
    end
    wr(ADDR_CTRL_ONE, 8'h00);
    wr(ADDR_CTRL_TWO, 8'h10);
  endtask : t_shot_noise
  task automatic t_boot_reset;
    nvmSeed = 5'h1b;
    wr(ADDR_CTRL_TWO, 8'h90);
    wait_trim(5'h1b);
    rd(ADDR_CTRL_TWO, 1);
    `CHK("boot clear", 8'h10, host_u.rxq[0])
    wr(ADDR_INT_ROUTE, 8'h3c);
    wr(ADDR_CTRL_TWO, 8'h46);
    rd(ADDR_INT_ROUTE, 1);
    `CHK("route reset", 8'h00, host_u.rxq[0])
    `CHK("thr reset", 5'h00, thresholdLevel)
    rd(ADDR_CTRL_TWO, 1);
    `CHK("ctrl reset", 8'h10, host_u.rxq[0])
  endtask : t_boot_reset
  // ==========================================================
  // clock and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {arst_n, measDone, dataReady, fifoOverwritten, pressHighEvt, pressLowEvt} = 6'h00;
    {autoZeroEn, autoRefEn, refCapture, nvmSeed, fifoLevel, refValue} = 32'h0;
    fifoPressData = 24'h123456;
    fifoTempData = 16'h789a;
    {err_total, checked, shotCnt, popCnt} = '0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    t_defaults();
    t_fifo_cfg();
    t_pin();
    t_ref();
    t_queue();
    t_shot_noise();
    t_boot_reset();
    summarize();
  end
endmodule : tb
`default_nettype wire
